// *** design/mamd_pkg.sv ***
/*
  Shared constants for the memory address map decoder: program space
  layout, data space layout, widths and the program port source type.
  Assumes nothing of its surroundings.
*/
package mamd_pkg;
  // widths
  localparam int PROG_AW = 24;
  localparam int IP_W    = 23;
  localparam int DATA_AW = 16;
  localparam int WORD_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int RAM_AW  = 14;
  localparam int PAGE_W  = 8;

  // program space map
  localparam logic [23:0] RESET_ADDR   = 24'h000000;
  localparam logic [23:0] RESET_TARGET = 24'h000002;
  localparam logic [23:0] IVT_LO       = 24'h000004;
  localparam logic [23:0] IVT_HI       = 24'h0000FF;
  localparam logic [23:0] AIVT_LO      = 24'h000100;
  localparam logic [23:0] AIVT_HI      = 24'h0001FF;
  localparam logic [23:0] VEC_END      = 24'h000200;
  localparam logic [23:0] USER_TOP     = 24'h7FFFFF;
  localparam int          CFG_PAGE_BIT = 7;

  // instruction pointer
  localparam logic [22:0] IP_RESET = 23'h000000;
  localparam logic [22:0] IP_STEP  = 23'h000002;

  // data space map
  localparam int          PSV_EA_BIT = 15;
  localparam logic [15:0] IMPL_LIMIT = 16'h7800;

  // who owns the program port in a cycle
  typedef enum logic [2:0] {
    SRC_FETCH = 3'b001,
    SRC_TABLE = 3'b010,
    SRC_PSV   = 3'b100
  } mamd_src_e;
endpackage

// *** design/mamd_prog_decode.sv ***
/*
  Combinational region decode of a 24-bit program address.
  Assumes the caller registers the flags before they leave the block.
*/
`timescale 1ns/1ps
module mamd_prog_decode (
  // address
  input  logic [mamd_pkg::PROG_AW-1:0] addr_in,
  // region flags
  output logic                         reset_slot_out,
  output logic                         primary_ivt_out,
  output logic                         alt_ivt_out,
  output logic                         vector_area_out,
  output logic                         upper_half_out
);
  import mamd_pkg::*;

  assign reset_slot_out  = addr_in < IVT_LO;
  assign primary_ivt_out = (addr_in >= IVT_LO)
                        && (addr_in <= IVT_HI);
  assign alt_ivt_out     = (addr_in >= AIVT_LO)
                        && (addr_in <= AIVT_HI);
  assign vector_area_out = addr_in < VEC_END;
  assign upper_half_out  = addr_in > USER_TOP;
endmodule

// *** design/mamd_byte_lane.sv ***
/*
  Byte lane steering for one data-space access: read byte select onto
  the low lane, write lane enables and write data replication.
  Assumes a 16-bit word with the low byte at the even address.
*/
`timescale 1ns/1ps
module mamd_byte_lane (
  // access
  input  logic                        byte_in,
  input  logic                        lsb_in,
  // read path
  input  logic [mamd_pkg::WORD_W-1:0] word_in,
  output logic [mamd_pkg::WORD_W-1:0] rdata_out,
  // write path
  input  logic [mamd_pkg::WORD_W-1:0] wdata_in,
  output logic [mamd_pkg::WORD_W-1:0] wdata_out,
  output logic [1:0]                  lane_out
);
  import mamd_pkg::*;

  logic [BYTE_W-1:0] sel_byte;

  // odd address holds the high byte
  assign sel_byte  = lsb_in ? word_in[15:8] : word_in[7:0];
  assign rdata_out = byte_in ? {8'h00, sel_byte} : word_in;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_lane
      assign lane_out[i] = ~byte_in | (lsb_in == 1'(i));
      assign wdata_out[BYTE_W*i +: BYTE_W] =
        byte_in ? wdata_in[7:0] : wdata_in[BYTE_W*i +: BYTE_W];
    end
  endgenerate
endmodule

// *** design/mamd_top.sv ***
/*
  Memory address map decoder: pointer, program port arbitration, vector
  flags, data-space read and write decode, byte lanes, misalignment.
  Assumes memories answer combinationally to the registered addresses
  and no table operation meets a windowed data read in one cycle.
*/
`timescale 1ns/1ps
module mamd_top (
  // clock and reset
  input  logic                         clock_in,
  input  logic                         rst_in,
  // instruction pointer control
  input  logic                         ip_load_in,
  input  logic [mamd_pkg::IP_W-1:0]    ip_target_in,
  input  logic                         ip_step_in,
  input  logic                         ip_back_in,
  output logic [mamd_pkg::IP_W-1:0]    ip_out,
  // table operations
  input  logic                         table_read_op_in,
  input  logic                         table_write_op_in,
  input  logic [mamd_pkg::PAGE_W-1:0]  table_page_register_in,
  input  logic [mamd_pkg::WORD_W-1:0]  table_offset_in,
  input  logic [mamd_pkg::WORD_W-1:0]  table_wdata_in,
  output logic [mamd_pkg::WORD_W-1:0]  table_rdata_out,
  output logic                         table_rvalid_out,
  // data window page
  input  logic [mamd_pkg::PAGE_W-1:0]  psv_page_in,
  // program memory port
  output logic [mamd_pkg::PROG_AW-1:0] prog_addr_out,
  output logic                         prog_rd_en_out,
  output logic                         prog_wr_low_out,
  output logic                         prog_wr_high_out,
  output logic [mamd_pkg::PROG_AW-1:0] prog_wdata_out,
  input  logic [mamd_pkg::PROG_AW-1:0] prog_rdata_in,
  output mamd_pkg::mamd_src_e          prog_src_out,
  output logic                         prog_cfg_sel_out,
  // vector region flags
  output logic                         reset_slot_out,
  output logic                         primary_ivt_out,
  output logic                         alt_ivt_out,
  output logic                         vector_area_out,
  // read address generator
  input  logic                         rd_req_in,
  input  logic [mamd_pkg::DATA_AW-1:0] rd_ea_in,
  input  logic                         rd_byte_in,
  output logic [mamd_pkg::WORD_W-1:0]  rd_data_out,
  output logic                         rd_valid_out,
  // write address generator
  input  logic                         wr_req_in,
  input  logic [mamd_pkg::DATA_AW-1:0] wr_ea_in,
  input  logic                         wr_byte_in,
  input  logic [mamd_pkg::WORD_W-1:0]  wr_data_in,
  // data ram port
  output logic                         ram_rd_en_out,
  output logic [mamd_pkg::RAM_AW-1:0]  ram_rd_addr_out,
  input  logic [mamd_pkg::WORD_W-1:0]  ram_rdata_in,
  output logic                         ram_wr_en_out,
  output logic [mamd_pkg::RAM_AW-1:0]  ram_wr_addr_out,
  output logic [1:0]                   ram_wr_lane_out,
  output logic [mamd_pkg::WORD_W-1:0]  ram_wdata_out,
  // fault
  output logic                         addr_err_out
);
  import mamd_pkg::*;
  logic [IP_W-1:0]    ip_ff;
  logic [PROG_AW-1:0] prog_addr_ff;
  logic               prog_rd_en_ff;
  logic               prog_wr_low_ff;
  logic               prog_wr_high_ff;
  logic [PROG_AW-1:0] prog_wdata_ff;
  mamd_src_e          src_ff;
  logic               cfg_sel_ff;
  logic               reset_slot_ff;
  logic               primary_ivt_ff;
  logic               alt_ivt_ff;
  logic               vector_area_ff;
  logic               tbl_pend_ff;
  logic               tbl_upper_ff;
  logic [WORD_W-1:0]  tbl_rdata_ff;
  logic               tbl_rvalid_ff;
  logic               rd_pend_ff;
  logic               rd_psv_ff;
  logic               rd_unimpl_ff;
  logic               rd_lsb_ff;
  logic               rd_byte_ff;
  logic [WORD_W-1:0]  rd_data_ff;
  logic               rd_valid_ff;
  logic               ram_rd_en_ff;
  logic [RAM_AW-1:0]  ram_rd_addr_ff;
  logic               ram_wr_en_ff;
  logic [RAM_AW-1:0]  ram_wr_addr_ff;
  logic [1:0]         ram_wr_lane_ff;
  logic [WORD_W-1:0]  ram_wdata_ff;
  logic               addr_err_ff;
  // instruction pointer, always even
  wire [IP_W-1:0] nxt_ip =
    ip_load_in ? {ip_target_in[IP_W-1:1], 1'b0} :
    ip_step_in ? ip_ff + IP_STEP :
    ip_back_in ? ip_ff - IP_STEP : ip_ff;
  // program port arbitration
  wire tbl_op = table_read_op_in | table_write_op_in;
  wire psv_rd = rd_req_in & rd_ea_in[PSV_EA_BIT];
  wire [PROG_AW-1:0] tbl_addr =
    {table_page_register_in, table_offset_in[15:1], 1'b0};
  wire [PROG_AW-1:0] psv_addr =
    {1'b0, psv_page_in, rd_ea_in[14:1], 1'b0};
  wire [PROG_AW-1:0] fetch_addr = {1'b0, nxt_ip};
  wire [PROG_AW-1:0] nxt_prog_addr =
    tbl_op ? tbl_addr : psv_rd ? psv_addr : fetch_addr;
  mamd_src_e nxt_src;
  assign nxt_src = tbl_op ? SRC_TABLE : psv_rd ? SRC_PSV : SRC_FETCH;
  wire nxt_cfg_sel = tbl_op & table_page_register_in[CFG_PAGE_BIT];
  wire tbl_upper   = table_offset_in[0];
  // data space decode
  wire rd_misalign = rd_req_in & ~rd_byte_in & rd_ea_in[0];
  wire wr_misalign = wr_req_in & ~wr_byte_in & wr_ea_in[0];
  wire rd_impl = rd_ea_in < IMPL_LIMIT;
  wire wr_impl = wr_ea_in < IMPL_LIMIT;
  wire rd_ram  = rd_req_in & rd_impl;
  wire wr_ok   = wr_req_in & wr_impl & ~wr_misalign;
  wire rd_unimpl = ~rd_ea_in[PSV_EA_BIT] & ~rd_impl;
  wire rflag_slot;
  wire rflag_ivt;
  wire rflag_aivt;
  wire rflag_vec;
  mamd_prog_decode u_decode (
    .addr_in         (nxt_prog_addr),
    .reset_slot_out  (rflag_slot),
    .primary_ivt_out (rflag_ivt),
    .alt_ivt_out     (rflag_aivt),
    .vector_area_out (rflag_vec),
    .upper_half_out  ()
  );
  // read answer: window, ram or zero
  wire [WORD_W-1:0] rd_word =
    rd_psv_ff ? prog_rdata_in[WORD_W-1:0] :
    rd_unimpl_ff ? 16'h0000 : ram_rdata_in;
  wire [WORD_W-1:0] nxt_rd_data;
  mamd_byte_lane u_rd_lane (
    .byte_in   (rd_byte_ff),
    .lsb_in    (rd_lsb_ff),
    .word_in   (rd_word),
    .rdata_out (nxt_rd_data),
    .wdata_in  (16'h0000),
    .wdata_out (),
    .lane_out  ()
  );
  wire [WORD_W-1:0] nxt_wdata;
  wire [1:0]        nxt_lane;
  mamd_byte_lane u_wr_lane (
    .byte_in   (wr_byte_in),
    .lsb_in    (wr_ea_in[0]),
    .word_in   (16'h0000),
    .rdata_out (),
    .wdata_in  (wr_data_in),
    .wdata_out (nxt_wdata),
    .lane_out  (nxt_lane)
  );
  // upper word carries only the top 8 bits (23:16) of the location
  wire [WORD_W-1:0] nxt_tbl_rdata = tbl_upper_ff ?
    {8'h00, prog_rdata_in[23:16]} : prog_rdata_in[WORD_W-1:0];
  wire [PROG_AW-1:0] nxt_prog_wdata =
    {table_wdata_in[7:0], table_wdata_in};
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ip_ff          <= IP_RESET;
      prog_addr_ff   <= RESET_ADDR;
      src_ff         <= SRC_FETCH;
      prog_rd_en_ff  <= 1'b0;
      cfg_sel_ff     <= 1'b0;
      reset_slot_ff  <= 1'b0;
      primary_ivt_ff <= 1'b0;
      alt_ivt_ff     <= 1'b0;
      vector_area_ff <= 1'b0;
    end else begin
      ip_ff          <= nxt_ip;
      prog_addr_ff   <= nxt_prog_addr;
      src_ff         <= nxt_src;
      prog_rd_en_ff  <= ~table_write_op_in;
      cfg_sel_ff     <= nxt_cfg_sel;
      reset_slot_ff  <= rflag_slot;
      primary_ivt_ff <= rflag_ivt;
      alt_ivt_ff     <= rflag_aivt;
      vector_area_ff <= rflag_vec;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prog_wr_low_ff  <= 1'b0;
      prog_wr_high_ff <= 1'b0;
      prog_wdata_ff   <= 24'h000000;
      tbl_pend_ff     <= 1'b0;
      tbl_upper_ff    <= 1'b0;
      tbl_rdata_ff    <= 16'h0000;
      tbl_rvalid_ff   <= 1'b0;
    end else begin
      prog_wr_low_ff  <= table_write_op_in & ~tbl_upper;
      prog_wr_high_ff <= table_write_op_in & tbl_upper;
      prog_wdata_ff   <= nxt_prog_wdata;
      tbl_pend_ff     <= table_read_op_in;
      tbl_upper_ff    <= tbl_upper;
      tbl_rvalid_ff   <= tbl_pend_ff;
      if (tbl_pend_ff) begin
        tbl_rdata_ff <= nxt_tbl_rdata;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_pend_ff     <= 1'b0;
      rd_psv_ff      <= 1'b0;
      rd_unimpl_ff   <= 1'b0;
      rd_lsb_ff      <= 1'b0;
      rd_byte_ff     <= 1'b0;
      rd_data_ff     <= 16'h0000;
      rd_valid_ff    <= 1'b0;
      ram_rd_en_ff   <= 1'b0;
      ram_rd_addr_ff <= '0;
    end else begin
      rd_pend_ff     <= rd_req_in;
      rd_psv_ff      <= psv_rd;
      rd_unimpl_ff   <= rd_unimpl;
      rd_lsb_ff      <= rd_ea_in[0];
      rd_byte_ff     <= rd_byte_in;
      rd_valid_ff    <= rd_pend_ff;
      ram_rd_en_ff   <= rd_ram;
      ram_rd_addr_ff <= rd_ea_in[14:1];
      if (rd_pend_ff) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ram_wr_en_ff   <= 1'b0;
      ram_wr_addr_ff <= '0;
      ram_wr_lane_ff <= 2'h0;
      ram_wdata_ff   <= 16'h0000;
      addr_err_ff    <= 1'b0;
    end else begin
      ram_wr_en_ff   <= wr_ok;
      ram_wr_addr_ff <= wr_ea_in[14:1];
      ram_wr_lane_ff <= nxt_lane;
      ram_wdata_ff   <= nxt_wdata;
      addr_err_ff    <= rd_misalign | wr_misalign;
    end
  end

  assign ip_out           = ip_ff;
  assign prog_addr_out    = prog_addr_ff;
  assign prog_rd_en_out   = prog_rd_en_ff;
  assign prog_wr_low_out  = prog_wr_low_ff;
  assign prog_wr_high_out = prog_wr_high_ff;
  assign prog_wdata_out   = prog_wdata_ff;
  assign prog_src_out     = src_ff;
  assign prog_cfg_sel_out = cfg_sel_ff;
  assign reset_slot_out   = reset_slot_ff;
  assign primary_ivt_out  = primary_ivt_ff;
  assign alt_ivt_out      = alt_ivt_ff;
  assign vector_area_out  = vector_area_ff;
  assign table_rdata_out  = tbl_rdata_ff;
  assign table_rvalid_out = tbl_rvalid_ff;
  assign rd_data_out      = rd_data_ff;
  assign rd_valid_out     = rd_valid_ff;
  assign ram_rd_en_out    = ram_rd_en_ff;
  assign ram_rd_addr_out  = ram_rd_addr_ff;
  assign ram_wr_en_out    = ram_wr_en_ff;
  assign ram_wr_addr_out  = ram_wr_addr_ff;
  assign ram_wr_lane_out  = ram_wr_lane_ff;
  assign ram_wdata_out    = ram_wdata_ff;
  assign addr_err_out     = addr_err_ff;
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ip_even_a: assert property (ip_out[0] == 1'b0)
    else $error("pointer left word alignment");
  ip_step_a: assert property (
    !ip_load_in && ip_step_in |=> ip_out == $past(ip_out) + IP_STEP
  ) else $error("pointer did not advance by two");
  reset_start_a: assert property (
    $past(rst_in) && !rst_in |-> prog_addr_out == RESET_ADDR && ip_out == 0
  ) else $error("fetch did not start at zero");
  user_half_a: assert property (
    prog_src_out != SRC_TABLE |-> prog_addr_out <= USER_TOP
  ) else $error("ordinary access reached upper half");
  cfg_gate_a: assert property (
    prog_addr_out[23] |-> prog_src_out == SRC_TABLE && prog_cfg_sel_out
  ) else $error("upper half reached without table page bit");
  ivt_flag_a: assert property (
    primary_ivt_out |-> prog_addr_out >= IVT_LO && prog_addr_out <= IVT_HI
  ) else $error("primary vector flag wrong");
  psv_route_a: assert property (
    rd_req_in && rd_ea_in[15] && !tbl_op
    |=> prog_src_out == SRC_PSV && !ram_rd_en_out
  ) else $error("window read not routed to program port");
  unimp_zero_a: assert property (
    rd_req_in && !rd_ea_in[15] && rd_ea_in >= IMPL_LIMIT
    |=> ##1 rd_valid_out && rd_data_out == 16'h0000
  ) else $error("unimplemented read not zero");
  misalign_wr_a: assert property (
    wr_req_in && !wr_byte_in && wr_ea_in[0]
    |=> addr_err_out && !ram_wr_en_out
  ) else $error("misaligned write not suppressed");
  byte_lane_a: assert property (
    wr_req_in && wr_byte_in && wr_ea_in < IMPL_LIMIT
    |=> ram_wr_en_out && ram_wr_lane_out == {$past(wr_ea_in[0]),
                                             !$past(wr_ea_in[0])}
  ) else $error("byte write lane wrong");
  rd_done_a: assert property (
    rd_req_in && !rd_byte_in && rd_ea_in[0] |=> addr_err_out ##1 rd_valid_out
  ) else $error("misaligned read did not complete");
  cover property (table_read_op_in && table_page_register_in[7] ##2
                  table_rvalid_out);
  cover property (psv_rd ##2 rd_valid_out);
  cover property (wr_misalign ##1 addr_err_out);
  cover property (ip_load_in ##1 vector_area_out);
endmodule

// *** verif/mamd_mem_model.sv ***
/*
  Far-side memories for the map decoder: program memory as a fixed
  address pattern, data ram as a word array with one write line per lane.
  Assumes the decoder's clock and registered addresses.
*/
`timescale 1ns/1ps
module mamd_mem_model (
  // clock
  input  wire logic        clock_in,
  // program port
  input  wire logic [23:0] prog_addr_in,
  input  wire logic        prog_rd_en_in,
  output logic      [23:0] prog_rdata_out,
  // data ram port
  input  wire logic        ram_rd_en_in,
  input  wire logic [13:0] ram_rd_addr_in,
  output logic      [15:0] ram_rdata_out,
  input  wire logic        ram_wr_en_in,
  input  wire logic [13:0] ram_wr_addr_in,
  input  wire logic [1:0]  ram_wr_lane_in,
  input  wire logic [15:0] ram_wdata_in
);
  logic [15:0] ram [0:16383];
  logic [23:0] pat;
  logic [15:0] word;

  initial begin
    for (int i = 0; i < 16384; i++) begin
      ram[i] = 16'(i) ^ 16'hA5C3;
    end
  end

  // 24 bits per location, top byte of upper word absent
  assign pat = {prog_addr_in[7:0] ^ prog_addr_in[23:16] ^ 8'h3C,
                prog_addr_in[15:0] ^ 16'hC35A};
  // an idle port shows inverted data, never stale data
  assign prog_rdata_out = prog_rd_en_in ? pat : ~pat;
  assign word           = ram[ram_rd_addr_in];
  assign ram_rdata_out  = ram_rd_en_in ? word : ~word;

  // low byte even, high byte odd, separate lane writes
  always @(posedge clock_in) begin
    if (ram_wr_en_in && ram_wr_lane_in[0]) begin
      ram[ram_wr_addr_in][7:0] <= ram_wdata_in[7:0];
    end
    if (ram_wr_en_in && ram_wr_lane_in[1]) begin
      ram[ram_wr_addr_in][15:8] <= ram_wdata_in[15:8];
    end
  end
endmodule

// *** verif/mamd_top_test.sv ***
/*
  Self-checking bench for the map decoder: pointer, vector flags, table
  operations and random data reads and writes against a queue-free model.
  Assumes the memory model answers combinationally.
*/
`timescale 1ns/1ps
module mamd_top_test;
  import mamd_pkg::*;
  logic        clock_in, rst_in, ip_load_in, ip_step_in, ip_back_in;
  logic [22:0] ip_target_in, ip_out, ip_m;
  logic        table_read_op_in, table_write_op_in, table_rvalid_out;
  logic [7:0]  table_page_register_in, psv_page_in;
  logic [15:0] table_offset_in, table_wdata_in, table_rdata_out;
  logic [23:0] prog_addr_out, prog_wdata_out, prog_rdata_in;
  logic        prog_rd_en_out, prog_wr_low_out, prog_wr_high_out;
  mamd_src_e   prog_src_out;
  logic        prog_cfg_sel_out, reset_slot_out, primary_ivt_out;
  logic        alt_ivt_out, vector_area_out, rd_req_in, rd_byte_in;
  logic [15:0] rd_ea_in, rd_data_out, wr_ea_in, wr_data_in;
  logic [15:0] ram_rdata_in, ram_wdata_out;
  logic        rd_valid_out, wr_req_in, wr_byte_in, ram_rd_en_out;
  logic [13:0] ram_rd_addr_out, ram_wr_addr_out;
  logic        ram_wr_en_out, addr_err_out;
  logic [1:0]  ram_wr_lane_out;
  logic [15:0] exp_ram [int];
  logic [15:0] eas [8];
  logic [22:0] vtab [8];
  int          fails, checked, cycles, seed_v;

  mamd_top dut (.clock_in(clock_in), .rst_in(rst_in),
    .ip_load_in(ip_load_in), .ip_target_in(ip_target_in),
    .ip_step_in(ip_step_in), .ip_back_in(ip_back_in), .ip_out(ip_out),
    .table_read_op_in(table_read_op_in),
    .table_write_op_in(table_write_op_in),
    .table_page_register_in(table_page_register_in),
    .table_offset_in(table_offset_in), .table_wdata_in(table_wdata_in),
    .table_rdata_out(table_rdata_out),
    .table_rvalid_out(table_rvalid_out), .psv_page_in(psv_page_in),
    .prog_addr_out(prog_addr_out), .prog_rd_en_out(prog_rd_en_out),
    .prog_wr_low_out(prog_wr_low_out), .prog_wr_high_out(prog_wr_high_out),
    .prog_wdata_out(prog_wdata_out), .prog_rdata_in(prog_rdata_in),
    .prog_src_out(prog_src_out), .prog_cfg_sel_out(prog_cfg_sel_out),
    .reset_slot_out(reset_slot_out), .primary_ivt_out(primary_ivt_out),
    .alt_ivt_out(alt_ivt_out), .vector_area_out(vector_area_out),
    .rd_req_in(rd_req_in), .rd_ea_in(rd_ea_in), .rd_byte_in(rd_byte_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
    .wr_req_in(wr_req_in), .wr_ea_in(wr_ea_in), .wr_byte_in(wr_byte_in),
    .wr_data_in(wr_data_in), .ram_rd_en_out(ram_rd_en_out),
    .ram_rd_addr_out(ram_rd_addr_out), .ram_rdata_in(ram_rdata_in),
    .ram_wr_en_out(ram_wr_en_out), .ram_wr_addr_out(ram_wr_addr_out),
    .ram_wr_lane_out(ram_wr_lane_out), .ram_wdata_out(ram_wdata_out),
    .addr_err_out(addr_err_out));

  mamd_mem_model mem (.clock_in(clock_in), .prog_addr_in(prog_addr_out),
    .prog_rd_en_in(prog_rd_en_out), .prog_rdata_out(prog_rdata_in),
    .ram_rd_en_in(ram_rd_en_out), .ram_rd_addr_in(ram_rd_addr_out),
    .ram_rdata_out(ram_rdata_in), .ram_wr_en_in(ram_wr_en_out),
    .ram_wr_addr_in(ram_wr_addr_out), .ram_wr_lane_in(ram_wr_lane_out),
    .ram_wdata_in(ram_wdata_out));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [23:0] prog_pat(input logic [23:0] a);
    return {a[7:0] ^ a[23:16] ^ 8'h3C, a[15:0] ^ 16'hC35A};
  endfunction

  function automatic logic [15:0] ram_get(input int i);
    return exp_ram.exists(i) ? exp_ram[i] : 16'(i) ^ 16'hA5C3;
  endfunction

  task automatic ip_op(input logic ld, st, bk, input logic [22:0] tgt);
    ip_load_in = ld;
    ip_step_in = st;
    ip_back_in = bk;
    ip_target_in = tgt;
    if (ld) ip_m = {tgt[22:1], 1'b0};
    else if (st) ip_m = ip_m + 23'h2;
    else if (bk) ip_m = ip_m - 23'h2;
    @(negedge clock_in);
    {ip_load_in, ip_step_in, ip_back_in} = 3'h0;
    check("ip", ip_out, ip_m);
    check("fetch_addr", prog_addr_out, {1'b0, ip_m});
    check("fetch_src", prog_src_out, SRC_FETCH);
    check("reset_slot", reset_slot_out, ip_m < 23'h4);
    check("ivt", primary_ivt_out, ip_m >= 23'h4 && ip_m <= 23'hFF);
    check("alt_ivt", alt_ivt_out, ip_m[22:8] == 15'h0001);
    check("vec_area", vector_area_out, ip_m < 23'h200);
    @(negedge clock_in);
  endtask

  task automatic tbl(input logic wr, input logic [7:0] pg,
                     input logic [15:0] off, wd);
    logic [23:0] a, p;
    logic [15:0] e;
    a = {pg, off[15:1], 1'b0};
    p = prog_pat(a);
    e = off[0] ? {8'h00, p[23:16]} : p[15:0];
    table_read_op_in = !wr;
    table_write_op_in = wr;
    table_page_register_in = pg;
    table_offset_in = off;
    table_wdata_in = wd;
    @(negedge clock_in);
    {table_read_op_in, table_write_op_in} = 2'h0;
    check("tbl_addr", prog_addr_out, a);
    check("tbl_valid0", table_rvalid_out, 1'b0);
    check("prog_rd_en", prog_rd_en_out, !wr);
    check("tbl_src", prog_src_out, SRC_TABLE);
    check("cfg_sel", prog_cfg_sel_out, pg[7]);
    if (wr) begin
      check("wr_low", prog_wr_low_out, !off[0]);
      check("wr_high", prog_wr_high_out, off[0]);
      check("pwdata", prog_wdata_out, {wd[7:0], wd});
    end
    @(negedge clock_in);
    check("tbl_valid", table_rvalid_out, !wr);
    if (!wr) begin
      check("tbl_data", table_rdata_out, e);
    end
  endtask

  task automatic dwr(input logic [15:0] ea, input logic b,
                     input logic [15:0] d);
    logic ok;
    logic [1:0] ln;
    logic [15:0] w;
    ok = (b || !ea[0]) && ea < 16'h7800;
    ln = b ? (ea[0] ? 2'h2 : 2'h1) : 2'h3;
    wr_req_in = 1'b1;
    wr_ea_in = ea;
    wr_byte_in = b;
    wr_data_in = d;
    @(negedge clock_in);
    wr_req_in = 1'b0;
    check("err_w", addr_err_out, !b && ea[0]);
    check("wr_en", ram_wr_en_out, ok);
    if (ok) begin
      check("wr_addr", ram_wr_addr_out, ea[14:1]);
      check("wr_lane", ram_wr_lane_out, ln);
      check("wr_data", ram_wdata_out, b ? {2{d[7:0]}} : d);
      w = ram_get(int'(ea[14:1]));
      if (ln[0]) w[7:0] = d[7:0];
      if (ln[1]) w[15:8] = b ? d[7:0] : d[15:8];
      exp_ram[int'(ea[14:1])] = w;
    end
    @(negedge clock_in);
  endtask

  task automatic drd(input logic [15:0] ea, input logic b,
                     input logic [7:0] pg);
    logic [23:0] pa, p;
    logic [15:0] w;
    pa = {1'b0, pg, ea[14:1], 1'b0};
    p = prog_pat(pa);
    w = ea < 16'h7800 ? ram_get(int'(ea[14:1])) : 16'h0000;
    if (ea[15]) w = p[15:0];
    if (b) w = ea[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    rd_req_in = 1'b1;
    rd_ea_in = ea;
    rd_byte_in = b;
    psv_page_in = pg;
    @(negedge clock_in);
    rd_req_in = 1'b0;
    check("err_r", addr_err_out, !b && ea[0]);
    check("rd_valid0", rd_valid_out, 1'b0);
    check("rd_en", ram_rd_en_out, ea < 16'h7800);
    if (ea[15]) begin
      check("win_src", prog_src_out, SRC_PSV);
      check("win_addr", prog_addr_out, pa);
    end else if (ea < 16'h7800) begin
      check("rd_addr", ram_rd_addr_out, ea[14:1]);
    end
    @(negedge clock_in);
    check("rd_valid", rd_valid_out, 1'b1);
    check("rd_data", rd_data_out, w);
  endtask

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // hang guard: whole run needs well under 1000 cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    {ip_load_in, ip_step_in, ip_back_in, rd_req_in, wr_req_in} = 5'h0;
    {table_read_op_in, table_write_op_in, rd_byte_in, wr_byte_in} = 4'h0;
    {ip_target_in, table_page_register_in, psv_page_in} = 39'h0;
    {table_offset_in, table_wdata_in, rd_ea_in, wr_ea_in} = 64'h0;
    wr_data_in = 16'h0000;
    seed_v = $urandom(32'hF3327E1D);
    vtab = '{23'h0, 23'h2, 23'h4, 23'hFE, 23'h100, 23'h1FE, 23'h200,
             23'h7FFFFF};
    // second pass resets in mid-run, pointer away from zero
    repeat (2) begin
      rst_in = 1'b1;
      ip_m = 23'h0;
      repeat (2) @(negedge clock_in);
      rst_in = 1'b0;
      check("rst_ip", ip_out, 23'h0);
      check("rst_addr", prog_addr_out, 24'h0);
      check("rst_src", prog_src_out, SRC_FETCH);
      ip_op(1'b0, 1'b1, 1'b0, 23'h0);
      ip_op(1'b0, 1'b1, 1'b0, 23'h0);
      ip_op(1'b0, 1'b0, 1'b1, 23'h0);
      ip_op(1'b1, 1'b1, 1'b1, 23'h123457);
      ip_op(1'b0, 1'b1, 1'b1, 23'h0);
      foreach (vtab[k]) ip_op(1'b1, 1'b0, 1'b0, vtab[k]);
    end
    foreach (vtab[k]) begin
      tbl(k[0], {k[2], 7'(k * 37)}, 16'($urandom), 16'($urandom));
    end
    eas = '{16'h0000, 16'h0002, 16'h77FE, 16'h7800, 16'h7FFE, 16'h8000,
            16'hFFFE, 16'h0000};
    eas[7] = 16'($urandom_range(0, 16'h77FE)) & 16'hFFFE;
    repeat (80) begin
      if ($urandom_range(0, 1) == 1) begin
        dwr(eas[$urandom_range(0, 7)] | 16'($urandom_range(0, 1)),
            1'($urandom_range(0, 1)), 16'($urandom));
      end else begin
        drd(eas[$urandom_range(0, 7)] | 16'($urandom_range(0, 1)),
            1'($urandom_range(0, 1)), 8'($urandom));
      end
    end
    tally_and_finish();
  end
endmodule
